// ### pkg/cacs_consts.svh
// Constants for the charge conversion sequencer
`ifndef CACS_CONSTS_SVH
`define CACS_CONSTS_SVH
`define CACS_CLK_PERIOD_PS   4000
`define CACS_SEQ_TIME_PS     5700000
`define CACS_VALID_MAX       12'hF00
`define CACS_CODE_MAX        12'hFFF
`define CACS_SLIDE_STEP      12'h001
`define CACS_EVENTS          32
`define CACS_DISCHARGE_CYC   8
`endif

// ### pkg/cacs_pkg.sv
// Types for the charge conversion sequencer
`default_nettype none
package cacs_pkg;
  typedef enum logic [2:0] {CACS_IDLE, CACS_GATE, CACS_CONV, CACS_DISCH} cacs_state_t;
endpackage : cacs_pkg
`default_nettype wire

// ### hw/cacs_corrector.sv
// Sliding-scale subtraction and acceptance for one converter result
`timescale 1ns/1ps
`default_nettype none
`include "cacs_consts.svh"
module cacs_corrector
  import cacs_pkg::*;
(
  // Converter result
  input  wire logic [11:0] raw,
  input  wire logic        raw_ovf,
  input  wire logic [11:0] offset,
  input  wire logic        slide_en,
  // Acceptance controls
  input  wire logic [11:0] threshold,
  input  wire logic        kill,
  // Result
  output logic      [11:0] value,
  output logic             accept,
  output logic             invalid
);
  logic [11:0] sub;
  always_comb
  begin
    sub     = slide_en ? raw - offset : raw;
    value   = sub;
    invalid = slide_en && (sub > `CACS_VALID_MAX);
    accept  = (sub >= threshold) && !raw_ovf && !kill && !invalid;
  end
endmodule : cacs_corrector
`default_nettype wire

// ### hw/cacs_sequencer.sv
// Integrate / digitise / discharge sequencer for 32 channels on two converters
`timescale 1ns/1ps
`default_nettype none
`include "cacs_consts.svh"
module cacs_sequencer
  import cacs_pkg::*;
#(
  parameter int CH   = 32,
  parameter int PER  = 16,
  parameter int MUXW = 4
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Gates
  input  wire logic [CH-1:0]     channel_gate,
  input  wire logic              shared_gate,
  // Converter A and B
  input  wire logic [11:0]       conv_a_data,
  input  wire logic              conv_a_ovf,
  input  wire logic [11:0]       conv_b_data,
  input  wire logic              conv_b_ovf,
  // Configuration
  input  wire logic              slide_en,
  input  wire logic [11:0]       threshold,
  input  wire logic [CH-1:0]     kill,
  // Buffer read port
  input  wire logic [9:0]        rd_addr,
  // Analog switch controls
  output logic      [CH-1:0]     channel_gate_switch,
  output logic                   shared_gate_switch,
  output logic      [CH-1:0]     integrator_discharge_switch,
  output logic      [1:0]        mux_group_sel,
  output logic      [1:0]        mux_chan_sel,
  output logic                   convert_start,
  output logic      [11:0]       slide_offset,
  // Status and buffer
  output logic                   busy,
  output logic      [4:0]        wr_event,
  output logic      [17:0]       rd_data
);
  localparam int SEQ_CYC = `CACS_SEQ_TIME_PS / `CACS_CLK_PERIOD_PS;
  localparam int SLOT    = SEQ_CYC / PER;
  // Slot decode assumes two 16-channel halves of 4-way groups
  if (CH != 2 * PER || PER != MUXW * 4 || SLOT < 2)
  begin : g_bad_layout
    $error("cacs_sequencer: unsupported channel layout");
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  cacs_state_t   st_q, st_d;
  logic [15:0]   cnt_q, cnt_d;
  logic [3:0]    slot_q, slot_d;
  logic [4:0]    wr_q, wr_d;
  logic [11:0]   off_q, off_d;
  logic          any_gate;
  logic          last_tick;

  assign any_gate  = shared_gate && |channel_gate;
  assign last_tick = (cnt_q == 16'(SLOT - 1));

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    slot_d = slot_q;
    wr_d   = wr_q;
    off_d  = off_q;
    unique case (st_q)
      CACS_IDLE:
        if (any_gate)
          st_d = CACS_GATE;
      CACS_GATE:
        if (!any_gate)
        begin
          st_d   = CACS_CONV;
          cnt_d  = '0;
          slot_d = '0;
        end
      CACS_CONV:
        begin
          cnt_d = last_tick ? '0 : cnt_q + 16'h0001;
          if (last_tick)
          begin
            slot_d = slot_q + 4'h1;
            if (slot_q == 4'(PER - 1))
            begin
              st_d  = CACS_DISCH;
              wr_d  = wr_q + 5'h01;
              off_d = off_q + `CACS_SLIDE_STEP;
            end
          end
        end
      CACS_DISCH:
        begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == 16'(`CACS_DISCHARGE_CYC - 1))
          begin
            st_d  = CACS_IDLE;
            cnt_d = '0;
          end
        end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q   <= CACS_IDLE;
      cnt_q  <= '0;
      slot_q <= '0;
      wr_q   <= '0;
      off_q  <= '0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      slot_q <= slot_d;
      wr_q   <= wr_d;
      off_q  <= off_d;
    end
  end

  // ****************************************
  // Correction and acceptance
  // ****************************************
  logic [11:0] val_a, val_b;
  logic        acc_a, acc_b;
  logic [4:0]  ch_a, ch_b;
  assign ch_a = {1'b0, slot_q};
  assign ch_b = {1'b1, slot_q};

  cacs_corrector u_corr_a (
    .raw       (conv_a_data),
    .raw_ovf   (conv_a_ovf),
    .offset    (off_q),
    .slide_en  (slide_en),
    .threshold (threshold),
    .kill      (kill[ch_a]),
    .value     (val_a),
    .accept    (acc_a),
    .invalid   ()
  );
  cacs_corrector u_corr_b (
    .raw       (conv_b_data),
    .raw_ovf   (conv_b_ovf),
    .offset    (off_q),
    .slide_en  (slide_en),
    .threshold (threshold),
    .kill      (kill[ch_b]),
    .value     (val_b),
    .accept    (acc_b),
    .invalid   ()
  );

  // ****************************************
  // Event memory: 32 events x 32 channels
  // ****************************************
  // Word: accepted flag, channel, value; two write ports, one read port
  logic [17:0] mem [0:`CACS_EVENTS*CH-1];
  logic        sample;
  assign sample = (st_q == CACS_CONV) && last_tick;

  always_ff @(posedge clock)
  begin
    if (sample)
    begin
      mem[{wr_q, ch_a}] <= {acc_a, ch_a, val_a};
      mem[{wr_q, ch_b}] <= {acc_b, ch_b, val_b};
    end
    rd_data <= mem[rd_addr];
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic [CH-1:0] gsw_d;
  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : g_gate
      assign gsw_d[g] = channel_gate[g] && shared_gate
                        && (st_q inside {CACS_IDLE, CACS_GATE});
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      channel_gate_switch         <= '0;
      shared_gate_switch          <= 1'b0;
      integrator_discharge_switch <= '0;
      mux_group_sel               <= '0;
      mux_chan_sel                <= '0;
      convert_start               <= 1'b0;
      slide_offset                <= '0;
      busy                        <= 1'b0;
      wr_event                    <= '0;
    end
    else
    begin
      channel_gate_switch         <= gsw_d;
      shared_gate_switch          <= shared_gate && (st_d != CACS_CONV) && (st_d != CACS_DISCH);
      integrator_discharge_switch <= {CH{st_d == CACS_DISCH}};
      mux_group_sel               <= slot_d[3:2];
      mux_chan_sel                <= slot_d[1:0];
      convert_start               <= (st_d == CACS_CONV) && (cnt_d == '0);
      slide_offset                <= slide_en ? off_d : '0;
      busy                        <= (st_d == CACS_CONV) || (st_d == CACS_DISCH);
      wr_event                    <= wr_d;
    end
  end
endmodule : cacs_sequencer
`default_nettype wire

// ### bench/cacs_properties.sv
// Checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module cacs_checker
  import cacs_pkg::*;
#(parameter int CH = 32)
(
  // Clock, reset, inputs
  input wire logic          clock,
  input wire logic          rst,
  input wire logic [CH-1:0] channel_gate,
  input wire logic          shared_gate,
  input wire logic          slide_en,
  // Outputs
  input wire logic [CH-1:0] channel_gate_switch,
  input wire logic          shared_gate_switch,
  input wire logic [CH-1:0] integrator_discharge_switch,
  input wire logic          convert_start,
  input wire logic [11:0]   slide_offset,
  input wire logic          busy,
  input wire logic [4:0]    wr_event
);
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic        dis;
  // Busy span count, far beyond any repetition bound
  always_comb cnt_d = busy ? cnt_q + 11'h001 : 11'h000;
  always_ff @(posedge clock) cnt_q <= rst ? 11'h000 : cnt_d;
  assign dis = |integrator_discharge_switch;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_GATE_AND: assert property ((channel_gate_switch & ~$past(channel_gate)) == '0
    && (!shared_gate_switch || $past(shared_gate))) else $error("gate switch without gates");
  AST_HOLD_OFF: assert property (busy |-> !shared_gate_switch && channel_gate_switch == '0)
    else $error("gate switch closed while busy");
  AST_START: assert property ($rose(busy) |-> convert_start) else $error("no start");
  AST_SLOT_GAP: assert property (convert_start |=> (!convert_start)[*8])
    else $error("slots too close");
  // Sixteen slots of 89 cycles plus 8 discharge cycles
  AST_SEQ_LEN: assert property ($fell(busy) |-> cnt_q == 11'h598)
    else $error("sequence length wrong");
  AST_DISCH_LEN: assert property ($rose(dis) |-> dis[*8] ##1 !dis)
    else $error("discharge length wrong");
  AST_DISCH_BUSY: assert property (dis |-> busy && !convert_start)
    else $error("discharge outside sequence");
  AST_WR_STEP: assert property ($changed(wr_event) |-> wr_event == $past(wr_event) + 5'h01)
    else $error("write pointer step wrong");
  AST_SLIDE_OFF: assert property (!slide_en && !$past(slide_en) |-> slide_offset == 12'h000)
    else $error("offset while slide off");
endmodule : cacs_checker
bind cacs_sequencer cacs_checker #(.CH(CH)) u_chk (.clock(clock), .rst(rst),
  .channel_gate(channel_gate), .shared_gate(shared_gate), .slide_en(slide_en),
  .channel_gate_switch(channel_gate_switch), .shared_gate_switch(shared_gate_switch),
  .integrator_discharge_switch(integrator_discharge_switch), .convert_start(convert_start),
  .slide_offset(slide_offset), .busy(busy), .wr_event(wr_event));
`default_nettype wire

// ### bench/cacs_conv_model.sv
// Converter pair model answering the slot selection
`timescale 1ns/1ps
`default_nettype none
module cacs_conv_model (
  // Selection and offset
  input wire logic [1:0]  mux_group_sel,
  input wire logic [1:0]  mux_chan_sel,
  input wire logic [11:0] slide_offset,
  // Analog levels
  input wire logic [11:0] lvl [32],
  input wire logic [31:0] ovf,
  // Results
  output logic [11:0]     conv_a_data,
  output logic            conv_a_ovf,
  output logic [11:0]     conv_b_data,
  output logic            conv_b_ovf
);
  logic [4:0] k;
  assign k = {1'b0, mux_group_sel, mux_chan_sel};
  // Offset added ahead of conversion
  assign conv_a_data = lvl[k] + slide_offset;
  assign conv_b_data = lvl[k + 5'h10] + slide_offset;
  assign conv_a_ovf = ovf[k];
  assign conv_b_ovf = ovf[k + 5'h10];
endmodule : cacs_conv_model
`default_nettype wire

// ### bench/cacs_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cacs_consts.svh"
module cacs_sequencer_test;
  logic clock = 0, rst = 1, shared_gate = 0, slide_en = 0, a_ov, b_ov, cs, sgs, busy, acc;
  logic [31:0] channel_gate = 0, kill = 0, ovf = 0, cgs, ids;
  logic [11:0] threshold = 0, thr, a_d, b_d, offs;
  logic [11:0] lvl [32];
  logic [9:0]  rd_addr = 0;
  logic [1:0]  gs, ks;
  logic [4:0]  wr_event, ev;
  logic [17:0] rd_data;
  int bad_count = 0, checks_done = 0, i, n, s;
  cacs_sequencer dut (.clock(clock), .rst(rst), .channel_gate(channel_gate),
    .shared_gate(shared_gate), .conv_a_data(a_d), .conv_a_ovf(a_ov), .conv_b_data(b_d),
    .conv_b_ovf(b_ov), .slide_en(slide_en), .threshold(threshold), .kill(kill),
    .rd_addr(rd_addr), .channel_gate_switch(cgs), .shared_gate_switch(sgs),
    .integrator_discharge_switch(ids), .mux_group_sel(gs), .mux_chan_sel(ks),
    .convert_start(cs), .slide_offset(offs), .busy(busy), .wr_event(wr_event),
    .rd_data(rd_data));
  cacs_conv_model conv (.mux_group_sel(gs), .mux_chan_sel(ks), .slide_offset(offs),
    .lvl(lvl), .ovf(ovf), .conv_a_data(a_d), .conv_a_ovf(a_ov), .conv_b_data(b_d),
    .conv_b_ovf(b_ov));
  // ****************
  // Checks and close
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial forever #2 clock = ~clock;
  // Four sequences take about 6000 cycles
  initial
  begin
    #60000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    i = $urandom(32'hF0517EB4);
    for (i = 0; i < 32; i++) lvl[i] = 12'h000;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (s = 0; s < 4; s++)
    begin
      @(posedge clock);
      thr = 12'($urandom % 3000);
      for (i = 3; i < 32; i++) lvl[i] <= 12'($urandom % 4000);
      lvl[0] <= 12'hF00;
      lvl[1] <= 12'hF01;
      lvl[2] <= thr;
      threshold <= thr;
      kill <= $urandom;
      ovf <= $urandom & $urandom;
      slide_en <= s[0];
      channel_gate <= $urandom;
      ev = wr_event;
      @(posedge clock) shared_gate <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(cgs, channel_gate);
      @(posedge clock) shared_gate <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 10) begin @(posedge clock); #1 n++; end
      chk({31'h0, busy}, 32'h1);
      // Offset steps once per finished sequence, shown only with slide on
      chk(offs, slide_en ? 12'(s * `CACS_SLIDE_STEP) : 12'h000);
      @(posedge clock) shared_gate <= 1'b1;
      repeat (4) @(posedge clock);
      #1 chk(cgs, 32'h0);
      @(posedge clock) shared_gate <= 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin @(posedge clock); #1 n++; end
      chk({31'h0, busy}, 32'h0);
      chk(wr_event, 5'(ev + 5'h01));
      for (i = 0; i < 32; i++)
      begin
        @(posedge clock) rd_addr <= {ev, 5'(i)};
        @(posedge clock);
        #1 acc = lvl[i] >= thr && !ovf[i] && !kill[i] && !(slide_en && lvl[i] > 12'hF00);
        chk({rd_data[17:12], acc ? rd_data[11:0] : 12'h0}, {acc, 5'(i), acc ? lvl[i] : 12'h0});
      end
    end
    end_of_test();
  end
endmodule : cacs_sequencer_test
`default_nettype wire
